//--- verilog/lgp_pkg.sv
package lgp_pkg;
  // Bus width and pixel formats
  localparam int unsigned BUS_W        = 16;
  localparam int unsigned PIX_W        = 18;
  localparam int unsigned FIFO_DEPTH   = 4;
  localparam int unsigned LINE_PIXELS  = 240;
  // Modes
  localparam logic [1:0] MODE_16_65K   = 2'h0;
  localparam logic [1:0] MODE_16_262K  = 2'h1;
  localparam logic [1:0] MODE_8_65K    = 2'h2;
  localparam logic [1:0] MODE_8_262K   = 2'h3;
  // Writes per line
  localparam logic [9:0] WR_16_65K     = 10'h0f0;
  localparam logic [9:0] WR_16_262K    = 10'h168;
  localparam logic [9:0] WR_8_65K      = 10'h1e0;
  localparam logic [9:0] WR_8_262K     = 10'h2d0;
  // Reset timing
  localparam int unsigned CLK_PERIOD_NS    = 5;
  localparam int unsigned CLEAR_PULSE_US   = 10;
  localparam int unsigned CLEAR_PULSE_CYC  = (CLEAR_PULSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CLEAR_WAIT_MS    = 120;
  localparam int unsigned CLEAR_WAIT_CYC   = CLEAR_WAIT_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned CNT_W            = 25;
endpackage : lgp_pkg

//--- verilog/lgp_fifo.sv
`timescale 1ns/1ps
module lgp_fifo #(
  parameter int unsigned WIDTH = 18,
  parameter int unsigned DEPTH = 4
) (
  // Clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_rst_b,
  // Fill side
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  // Drain side
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic             push, pop;

  always_comb begin
    push  = i_in_valid && o_in_ready;
    pop   = o_out_valid && i_out_ready;
    wr_d  = push ? wr_q + 1'b1 : wr_q;
    rd_d  = pop ? rd_q + 1'b1 : rd_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge i_clock) begin
    if (push) begin
      mem_q[wr_q] <= i_in_data;
    end
  end

  assign o_in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_q != '0);
  assign o_out_data  = mem_q[rd_q];
endmodule : lgp_fifo

//--- verilog/lgp_packer.sv
`timescale 1ns/1ps
// Notes on behaviour
// - 16-bit 262K: three writes carry two pixels
// - 8-bit 65K: two writes per pixel, upper lines
// - 8-bit 262K: three writes, R G B
// - 8-bit command on upper lines, select low
// - 16-bit 65K: one pixel per write
module lgp_packer
  import lgp_pkg::*;
#(
  parameter int unsigned CLEAR_PULSE_CYCLES = CLEAR_PULSE_CYC,
  parameter int unsigned CLEAR_WAIT_CYCLES  = CLEAR_WAIT_CYC
) (
  // Clock and reset
  input  wire logic              i_clock,
  input  wire logic              i_rst_b,
  // Configuration
  input  wire logic [1:0]        i_mode,
  input  wire logic              i_panel_reset_b,
  // Host bus, sampled writes
  input  wire logic              i_write_strobe,
  input  wire logic              i_reg_select,
  input  wire logic [BUS_W-1:0]  i_host_data_lines,
  output logic                   o_bus_ready,
  // Command out
  output logic                   o_cmd_valid,
  output logic [7:0]             o_cmd_byte,
  // Pixel stream out
  output logic                   o_pix_valid,
  input  wire logic              i_pix_ready,
  output logic [PIX_W-1:0]       o_pix_data,
  output logic                   o_line_done,
  // Status
  output logic                   o_ready_for_cmd
);
  typedef enum logic [2:0] {
    ST_CLEAR = 3'h1,
    ST_WAIT  = 3'h2,
    ST_RUN   = 3'h4
  } lgp_state_t;

  lgp_state_t        state_q, state_d;
  logic [CNT_W-1:0]  tmr_q, tmr_d;
  logic [1:0]        phase_q, phase_d;
  logic [9:0]        wcnt_q, wcnt_d;
  logic [17:6]       hold_q, hold_d;
  logic [11:6]       part_q, part_d;
  logic              cmd_v_q, cmd_v_d;
  logic [7:0]        cmd_q, cmd_d;
  logic              done_q, done_d;
  logic              f_valid, f_ready;
  logic [PIX_W-1:0]  f_data;
  logic              wr, dw;
  logic [15:0]       d;
  logic [9:0]        line_wr;
  logic              ld_zero;

  assign d  = i_host_data_lines;
  assign wr = i_write_strobe && state_q == ST_RUN;
  assign dw = wr && i_reg_select && f_ready;
  assign o_bus_ready     = f_ready;
  assign o_ready_for_cmd = (state_q == ST_RUN);

  always_comb begin
    case (i_mode)
      MODE_16_65K:  line_wr = WR_16_65K;
      MODE_16_262K: line_wr = WR_16_262K;
      MODE_8_65K:   line_wr = WR_8_65K;
      default:      line_wr = WR_8_262K;
    endcase
  end

  // Reset pulse qualification and release wait
  always_comb begin
    state_d = state_q;
    tmr_d   = tmr_q;
    ld_zero = 1'b0;
    case (state_q)
      ST_CLEAR: begin
        if (!i_panel_reset_b) begin
          tmr_d = (tmr_q == CNT_W'(CLEAR_PULSE_CYCLES)) ? tmr_q : tmr_q + 1'b1;
        end else if (tmr_q >= CNT_W'(CLEAR_PULSE_CYCLES)) begin
          state_d = ST_WAIT;
          tmr_d   = '0;
        end else begin
          tmr_d = '0;
        end
      end
      ST_WAIT: begin
        tmr_d = tmr_q + 1'b1;
        if (tmr_q >= CNT_W'(CLEAR_WAIT_CYCLES - 1)) begin
          state_d = ST_RUN;
          tmr_d   = '0;
        end
      end
      ST_RUN: begin
        if (!i_panel_reset_b) begin
          state_d = ST_CLEAR;
          tmr_d   = CNT_W'(1);
        end
      end
      default: state_d = ST_CLEAR;
    endcase
    if (state_q != ST_RUN) begin
      ld_zero = 1'b1;
    end
  end

  // Write decode and pixel assembly
  always_comb begin
    phase_d = phase_q;
    wcnt_d  = wcnt_q;
    hold_d  = hold_q;
    part_d  = part_q;
    cmd_v_d = 1'b0;
    cmd_d   = cmd_q;
    done_d  = 1'b0;
    f_valid = 1'b0;
    f_data  = '0;
    if (ld_zero) begin
      phase_d = '0;
      wcnt_d  = '0;
    end else if (wr && !i_reg_select) begin
      cmd_v_d = 1'b1;
      phase_d = '0;
      wcnt_d  = '0;
      if (i_mode[1]) begin
        cmd_d = d[15:8];
      end else begin
        cmd_d = d[7:0];
      end
    end else if (dw) begin
      wcnt_d  = (wcnt_q == line_wr - 10'h001) ? 10'h000 : wcnt_q + 10'h001;
      done_d  = (wcnt_q == line_wr - 10'h001);
      phase_d = phase_q + 2'h1;
      case (i_mode)
        MODE_16_65K: begin
          f_valid = 1'b1;
          f_data  = {d[15:11], 1'b0, d[10:5], d[4:0], 1'b0};
          phase_d = '0;
        end
        MODE_16_262K: begin
          if (phase_q == 2'h0) begin
            hold_d[17:6] = {d[15:10], d[7:2]};
          end else if (phase_q == 2'h1) begin
            f_valid = 1'b1;
            f_data  = {hold_q[17:6], d[15:10]};
            part_d[11:6] = d[7:2];
          end else begin
            f_valid = 1'b1;
            f_data  = {part_q[11:6], d[15:10], d[7:2]};
            phase_d = '0;
          end
        end
        MODE_8_65K: begin
          if (phase_q == 2'h0) begin
            hold_d[17:6] = {d[15:11], 1'b0, d[10:8], 3'h0};
          end else begin
            f_valid = 1'b1;
            f_data  = {hold_q[17:12], hold_q[11:9], d[15:13], d[12:8], 1'b0};
            phase_d = '0;
          end
        end
        default: begin
          if (phase_q == 2'h0) begin
            hold_d[17:12] = d[15:10];
          end else if (phase_q == 2'h1) begin
            hold_d[11:6] = d[15:10];
          end else begin
            f_valid = 1'b1;
            f_data  = {hold_q[17:6], d[15:10]};
            phase_d = '0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      state_q <= ST_CLEAR;
      tmr_q   <= '0;
      phase_q <= '0;
      wcnt_q  <= '0;
      hold_q  <= '0;
      part_q  <= '0;
      cmd_v_q <= 1'b0;
      cmd_q   <= '0;
      done_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      tmr_q   <= tmr_d;
      phase_q <= phase_d;
      wcnt_q  <= wcnt_d;
      hold_q  <= hold_d;
      part_q  <= part_d;
      cmd_v_q <= cmd_v_d;
      cmd_q   <= cmd_d;
      done_q  <= done_d;
    end
  end

  assign o_cmd_valid = cmd_v_q;
  assign o_cmd_byte  = cmd_q;
  assign o_line_done = done_q;

  lgp_fifo #(
    .WIDTH (PIX_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clock     (i_clock),
    .i_rst_b     (i_rst_b),
    .i_in_valid  (f_valid),
    .o_in_ready  (f_ready),
    .i_in_data   (f_data),
    .o_out_valid (o_pix_valid),
    .i_out_ready (i_pix_ready),
    .o_out_data  (o_pix_data)
  );

  property p_cmd_after_low_write;
    @(posedge i_clock) disable iff (!i_rst_b)
      (wr && !i_reg_select && i_mode[1]) |=> (o_cmd_valid && o_cmd_byte == $past(d[15:8]));
  endproperty
  a_cmd_after_low_write: assert property (p_cmd_after_low_write) else $error("command byte wrong");

  property p_wide_pixel;
    @(posedge i_clock) disable iff (!i_rst_b)
      (dw && i_mode == MODE_16_65K) |-> (f_valid && f_data[17:13] == d[15:11] && f_data[5:1] == d[4:0]);
  endproperty
  a_wide_pixel: assert property (p_wide_pixel) else $error("16-bit 65K pixel wrong");

  property p_262k_third;
    @(posedge i_clock) disable iff (!i_rst_b)
      (dw && i_mode == MODE_16_262K && phase_q == 2'h2) |-> (f_valid && f_data[5:0] == d[7:2]);
  endproperty
  a_262k_third: assert property (p_262k_third) else $error("second pixel blue wrong");

  property p_262k_first_none;
    @(posedge i_clock) disable iff (!i_rst_b)
      (dw && i_mode != MODE_16_65K && phase_q == 2'h0) |-> !f_valid;
  endproperty
  a_262k_first_none: assert property (p_262k_first_none) else $error("pixel on first write");

  property p_8_65k;
    @(posedge i_clock) disable iff (!i_rst_b)
      (dw && i_mode == MODE_8_65K && phase_q == 2'h1) |-> (f_valid && f_data[5:1] == d[12:8]);
  endproperty
  a_8_65k: assert property (p_8_65k) else $error("8-bit 65K blue wrong");

  property p_line_done;
    @(posedge i_clock) disable iff (!i_rst_b)
      (dw && i_mode == MODE_16_262K && wcnt_q == 10'h167) |=> (o_line_done && wcnt_q == 10'h000);
  endproperty
  a_line_done: assert property (p_line_done) else $error("line end not at 360");

  property p_short_pulse;
    @(posedge i_clock) disable iff (!i_rst_b)
      (state_q == ST_CLEAR && i_panel_reset_b && tmr_q < CNT_W'(CLEAR_PULSE_CYCLES)) |=> state_q == ST_CLEAR;
  endproperty
  a_short_pulse: assert property (p_short_pulse) else $error("short reset accepted");

  property p_wait_blocks;
    @(posedge i_clock) disable iff (!i_rst_b)
      (state_q == ST_WAIT) |-> (!o_ready_for_cmd && !o_cmd_valid && !o_line_done);
  endproperty
  a_wait_blocks: assert property (p_wait_blocks) else $error("ready during wait");
endmodule : lgp_packer

//--- bench/lgp_host.sv
`timescale 1ns/1ps
module lgp_host
  import lgp_pkg::*;
(
  // Clock
  input  wire logic             i_clock,
  // Host bus
  output logic                  o_write_strobe = 1'b0,
  output logic                  o_reg_select   = 1'b1,
  output logic [BUS_W-1:0]      o_data         = 16'h0000,
  output logic                  o_panel_reset_b = 1'b0
);
  // One write: held through the sampling edge, bus inverted when idle
  task automatic wr(input logic rs, input logic [BUS_W-1:0] d);
    @(posedge i_clock);
    o_write_strobe <= 1'b1;
    o_reg_select   <= rs;
    o_data         <= d;
    @(posedge i_clock);
    o_write_strobe <= 1'b0;
    o_data         <= ~d;
  endtask : wr

  // Panel reset pulse, low for low_cyc cycles
  task automatic panel_clear(input int low_cyc);
    @(posedge i_clock);
    o_panel_reset_b <= 1'b0;
    repeat (low_cyc) @(posedge i_clock);
    o_panel_reset_b <= 1'b1;
  endtask : panel_clear
endmodule : lgp_host

//--- bench/tb.sv
`timescale 1ns/1ps
module tb
  import lgp_pkg::*;
;
  logic             i_clock = 1'b0;
  logic             i_rst_b = 1'b0;
  logic [1:0]       i_mode  = 2'h0;
  logic             i_pix_ready = 1'b1;
  logic             strobe, rs, pclr_b, bus_rdy, cmd_v, pix_v, ldone, rdy_cmd;
  logic [BUS_W-1:0] data;
  logic [7:0]       cmd_b;
  logic [PIX_W-1:0] pix;
  logic [PIX_W-1:0] q[$];
  int               err_total = 0;
  int               samples_checked = 0;
  int               ld_cnt = 0;
  bit               hung = 1'b0;

  initial forever #2.5 i_clock = ~i_clock;

  lgp_host host_u (.i_clock(i_clock), .o_write_strobe(strobe), .o_reg_select(rs), .o_data(data),
                   .o_panel_reset_b(pclr_b));
  lgp_packer #(.CLEAR_PULSE_CYCLES(4), .CLEAR_WAIT_CYCLES(8)) dut_u (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_mode(i_mode), .i_panel_reset_b(pclr_b),
    .i_write_strobe(strobe), .i_reg_select(rs), .i_host_data_lines(data), .o_bus_ready(bus_rdy),
    .o_cmd_valid(cmd_v), .o_cmd_byte(cmd_b), .o_pix_valid(pix_v), .i_pix_ready(i_pix_ready),
    .o_pix_data(pix), .o_line_done(ldone), .o_ready_for_cmd(rdy_cmd));

  always @(posedge i_clock) begin
    if (pix_v === 1'b1 && i_pix_ready === 1'b1) q.push_back(pix);
    if (ldone === 1'b1) ld_cnt++;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clock);
  endtask : cyc

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results

  task automatic start_fmt(input logic [1:0] m, input logic [15:0] c);
    i_mode <= m;
    q.delete();
    host_u.wr(1'b0, c);
    @(negedge i_clock);
    chk("cmd_valid", cmd_v, 1'b1);
    chk("cmd_byte", cmd_b, m[1] ? c[15:8] : c[7:0]);
  endtask : start_fmt

  // Bounded wait for the panel to leave its reset wait
  task automatic wait_rdy();
    int n;
    n = 0;
    while (rdy_cmd !== 1'b1 && n < 100) begin
      cyc(1);
      n++;
    end
    if (n >= 100) begin
      err_total++;
      hung = 1'b1;
    end else begin
      chk("wait_len", n > 8, 1'b1);
    end
  endtask : wait_rdy

  task automatic t_16_65k();
    start_fmt(MODE_16_65K, 16'ha52c);
    chk("cmd_byte", cmd_b, 8'h2c);
    host_u.wr(1'b1, 16'h8421);
    cyc(4);
    chk("pix", q[0], {5'h10, 1'b0, 6'h21, 5'h01, 1'b0});
    $display("test 16_65k done");
  endtask : t_16_65k

  task automatic t_16_262k();
    start_fmt(MODE_16_262K, 16'h002c);
    host_u.wr(1'b1, 16'hfc04);
    host_u.wr(1'b1, 16'h08fc);
    host_u.wr(1'b1, 16'h1448);
    cyc(4);
    chk("pix_cnt", q.size(), 2);
    chk("pix0", q[0], {6'h3f, 6'h01, 6'h02});
    chk("pix1", q[1], {6'h3f, 6'h05, 6'h12});
    $display("test 16_262k done");
  endtask : t_16_262k

  task automatic t_8_65k();
    start_fmt(MODE_8_65K, 16'h2c5a);
    chk("cmd_byte", cmd_b, 8'h2c);
    host_u.wr(1'b1, 16'h8b00);
    host_u.wr(1'b1, 16'h6500);
    cyc(4);
    chk("pix", q[0], {5'h11, 1'b0, 6'h1b, 5'h05, 1'b0});
    $display("test 8_65k done");
  endtask : t_8_65k

  task automatic t_8_262k();
    start_fmt(MODE_8_262K, 16'h2c00);
    host_u.wr(1'b1, 16'h8700);
    host_u.wr(1'b1, 16'h1c00);
    host_u.wr(1'b1, 16'hfb00);
    cyc(4);
    chk("pix_cnt", q.size(), 1);
    chk("pix", q[0], {6'h21, 6'h07, 6'h3e});
    $display("test 8_262k done");
  endtask : t_8_262k

  task automatic t_line(input logic [1:0] m, input int n);
    start_fmt(m, 16'h2c2c);
    ld_cnt = 0;
    for (int i = 0; i < n - 1; i++) host_u.wr(1'b1, 16'(i * 16'h0104));
    cyc(3);
    chk("line_early", ld_cnt, 0);
    host_u.wr(1'b1, 16'hffff);
    cyc(3);
    chk("line_done", ld_cnt, 1);
    $display("test line mode %0d done", m);
  endtask : t_line

  task automatic t_fill();
    i_pix_ready <= 1'b0;
    start_fmt(MODE_16_65K, 16'h002c);
    for (int i = 0; i < 5; i++) host_u.wr(1'b1, 16'h1111 * i[15:0]);
    cyc(2);
    chk("bus_ready", bus_rdy, 1'b0);
    chk("pix_valid", pix_v, 1'b1);
    i_pix_ready <= 1'b1;
    cyc(10);
    chk("drained", q.size(), FIFO_DEPTH);
    chk("fill_last", q[3], {5'h06, 1'b0, 6'h19, 5'h13, 1'b0});
    chk("pix_valid", pix_v, 1'b0);
    $display("test fill done");
  endtask : t_fill

  // Short panel reset drops out of run and stays in clear, writes outside run are refused, long one restarts
  task automatic t_clear();
    host_u.panel_clear(2);
    host_u.wr(1'b0, 16'h2c2c);
    @(negedge i_clock);
    chk("cmd_refused", cmd_v, 1'b0);
    cyc(20);
    chk("short_clear", rdy_cmd, 1'b0);
    host_u.panel_clear(20);
    wait_rdy();
    $display("test clear done");
  endtask : t_clear

  task automatic run_all();
    t_16_65k();
    t_16_262k();
    t_8_65k();
    t_8_262k();
    t_line(MODE_16_65K, WR_16_65K);
    t_line(MODE_16_262K, WR_16_262K);
    t_line(MODE_8_65K, WR_8_65K);
    t_line(MODE_8_262K, WR_8_262K);
    t_fill();
    t_clear();
  endtask : run_all

  initial begin
    cyc(12);
    i_rst_b <= 1'b1;
    host_u.panel_clear(20);
    chk("early_ready", rdy_cmd, 1'b0);
    wait_rdy();
    if (!hung) run_all();
    results();
  end
endmodule : tb
